// ==== rtl/drive_status_defs.svh ====
`ifndef DRIVE_STATUS_DEFS_SVH
`define DRIVE_STATUS_DEFS_SVH

// register word addresses: object index and subindex, since several objects share an index
`define ADDR_STATE_FLAGS 16'h6041
`define ADDR_SPEED_TARGET 16'h6042
`define ADDR_SPEED_DEMAND 16'h6043
`define ADDR_SPEED_MEASURED 16'h6044
`define ADDR_LOWER_LIMIT 16'h6046
`define ADDR_UPPER_LIMIT 16'h6146
`define ADDR_ACCEL_SPEED 16'h6048
`define ADDR_ACCEL_TIME 16'h6148
`define ADDR_DECEL_SPEED 16'h6049
`define ADDR_DECEL_TIME 16'h6149
`define ADDR_IRQ_STATUS 16'h7000
`define ADDR_IRQ_ENABLE 16'h7001
`define ADDR_IRQ_CLEAR 16'h7002
`define ADDR_MODE 16'h7003

`define RST_SPEED_TARGET 16'h00C8
`define RST_LOWER_LIMIT 32'h0000_0000
`define RST_UPPER_LIMIT 32'h0000_4E20
`define RST_RAMP_SPEED 32'h0000_01F4
`define RST_RAMP_TIME 16'h0001

// status word bit positions
`define BIT_READY 0
`define BIT_SWITCHED_ON 1
`define BIT_OP_ENABLED 2
`define BIT_FAULT 3
`define BIT_VOLTAGE 4
`define BIT_EMERGENCY 5
`define BIT_INHIBITED 6
`define BIT_WARNING 7
`define BIT_SYNC 8
`define BIT_REMOTE 9
`define BIT_GOAL 10
`define BIT_LIMIT 11
`define BIT_MODE_LO 12
`define BIT_MODE_HI 13
`define BIT_LOOP 15

// interrupt event bits
`define EV_LIMIT 0
`define EV_GOAL 1
`define EV_FAULT 2
`define EV_WARNING 3
`define EV_COUNT 4

// velocity mode code in the mode register
`define MODE_VELOCITY 8'h02

`endif

// ==== rtl/drive_status_pkg.sv ====
package drive_status_pkg;

  typedef enum logic [2:0] {
    PS_NOT_READY = 3'b000,
    PS_INHIBITED = 3'b001,
    PS_READY = 3'b010,
    PS_SWITCHED_ON = 3'b011,
    PS_OP_ENABLED = 3'b100,
    PS_QUICK_STOP = 3'b101,
    PS_FAULT_REACT = 3'b110,
    PS_FAULT = 3'b111
  } power_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic signed [15:0] target;
    logic [31:0] lower;
    logic [31:0] upper;
  } clamp_in_t;

  typedef struct packed {
    logic signed [15:0] speed;
    logic limited;
  } clamp_out_t;

endpackage : drive_status_pkg

// ==== rtl/speed_clamp.sv ====
`timescale 1ns/1ps
`include "drive_status_defs.svh"

// =====================================================
// target clamp against the lower and upper speed limits
module speed_clamp
  import drive_status_pkg::*;
(
  input wire clamp_in_t clamp_i,
  output clamp_out_t clamp_o
);

  // limits are unsigned 32 bit; compare in 33 bit signed space so negative targets sort below zero
  wire signed [32:0] target_wide = {{17{clamp_i.target[15]}}, clamp_i.target};
  wire signed [32:0] lower_wide = {1'b0, clamp_i.lower};
  wire signed [32:0] upper_wide = {1'b0, clamp_i.upper};
  wire below = target_wide < lower_wide;
  wire above = target_wide > upper_wide;

  // limits above the 16 bit range saturate at the largest signed speed
  function automatic logic signed [15:0] sat16(input logic [31:0] v);
    sat16 = (v > 32'h0000_7FFF) ? 16'sh7FFF : v[15:0];
  endfunction : sat16

  assign clamp_o.speed = below ? sat16(clamp_i.lower) : (above ? sat16(clamp_i.upper) : clamp_i.target);
  assign clamp_o.limited = below | above;

endmodule : speed_clamp

// ==== rtl/drive_status_velocity.sv ====
`timescale 1ns/1ps
`include "drive_status_defs.svh"

module drive_status_velocity
  import drive_status_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic [2:0] POWER_STATE_I,
  input wire logic VOLTAGE_PRESENT_I,
  input wire logic FAULT_I,
  input wire logic WARNING_I,
  input wire logic SYNC_I,
  input wire logic LOOP_CLOSED_I,
  input wire logic [1:0] MODE_BITS_I,
  input wire logic signed [15:0] SPEED_MEASURED_I,
  output logic [15:0] STATUS_O,
  output logic signed [15:0] SPEED_DEMAND_O,
  output logic IRQ_O
);

  // =====================================================
  // pin synchronisers
  // status pins come from outside this clock; two stages before any use
  logic [25:0] sync_a;
  logic [25:0] sync_b;
  wire [25:0] pins = {POWER_STATE_I, VOLTAGE_PRESENT_I, FAULT_I, WARNING_I, SYNC_I, LOOP_CLOSED_I,
                      MODE_BITS_I, SPEED_MEASURED_I};

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      sync_a <= 26'h000_0000;
      sync_b <= 26'h000_0000;
    end
    else
    begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end

  wire power_state_t pstate = power_state_t'(sync_b[25:23]);
  wire voltage_present_flag = sync_b[22];
  wire fault_in = sync_b[21];
  wire warning_in = sync_b[20];
  wire sync_in = sync_b[19];
  wire loop_in = sync_b[18];
  wire [1:0] mode_pins = sync_b[17:16];
  // measured speed may tear across bits when it changes; the source should hold it stable for two cycles
  wire signed [15:0] measured_in = sync_b[15:0];

  // =====================================================
  // registers
  reg_req_t req;
  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

  logic signed [15:0] speed_target;
  logic signed [15:0] speed_measured;
  logic [31:0] speed_lower_limit;
  logic [31:0] speed_upper_limit;
  logic [31:0] accel_speed_step;
  logic [15:0] accel_time_step;
  logic [31:0] decel_speed_step;
  logic [15:0] decel_time_step;
  logic [7:0] op_mode;
  logic [`EV_COUNT-1:0] irq_status;
  logic [`EV_COUNT-1:0] irq_enable;

  function automatic logic hit(input reg_req_t r, input logic [15:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      speed_target <= `RST_SPEED_TARGET;
      speed_lower_limit <= `RST_LOWER_LIMIT;
      speed_upper_limit <= `RST_UPPER_LIMIT;
      accel_speed_step <= `RST_RAMP_SPEED;
      accel_time_step <= `RST_RAMP_TIME;
      decel_speed_step <= `RST_RAMP_SPEED;
      decel_time_step <= `RST_RAMP_TIME;
      op_mode <= `MODE_VELOCITY;
      irq_enable <= 4'h0;
    end
    else
    begin
      if (hit(req, `ADDR_SPEED_TARGET))
        speed_target <= req.wdata[15:0];
      if (hit(req, `ADDR_LOWER_LIMIT))
        speed_lower_limit <= req.wdata;
      if (hit(req, `ADDR_UPPER_LIMIT))
        speed_upper_limit <= req.wdata;
      if (hit(req, `ADDR_ACCEL_SPEED))
        accel_speed_step <= req.wdata;
      if (hit(req, `ADDR_ACCEL_TIME))
        accel_time_step <= req.wdata[15:0];
      if (hit(req, `ADDR_DECEL_SPEED))
        decel_speed_step <= req.wdata;
      if (hit(req, `ADDR_DECEL_TIME))
        decel_time_step <= req.wdata[15:0];
      if (hit(req, `ADDR_MODE))
        op_mode <= req.wdata[7:0];
      if (hit(req, `ADDR_IRQ_ENABLE))
        irq_enable <= req.wdata[`EV_COUNT-1:0];
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      speed_measured <= 16'h0000;
    else
      speed_measured <= measured_in;
  end

  // =====================================================
  // clamp and ramp
  clamp_out_t clamped;
  speed_clamp u_clamp (
    .clamp_i('{target: speed_target, lower: speed_lower_limit, upper: speed_upper_limit}),
    .clamp_o(clamped)
  );

  logic signed [15:0] speed_demand;
  logic [15:0] tick_count;
  wire velocity_mode = (op_mode == `MODE_VELOCITY);
  wire running = velocity_mode && (pstate == PS_OP_ENABLED);
  // moving away from zero accelerates, toward zero decelerates
  wire signed [17:0] dem_w = {{2{speed_demand[15]}}, speed_demand};
  wire signed [17:0] tgt_w = {{2{clamped.speed[15]}}, clamped.speed};
  wire going_up = tgt_w > dem_w;
  wire speeding = going_up ? (speed_demand >= 0) : (speed_demand <= 0);
  wire [31:0] step = speeding ? accel_speed_step : decel_speed_step;
  wire [15:0] period = speeding ? accel_time_step : decel_time_step;
  // a zero time step is treated as one tick
  wire tick = (tick_count + 16'h0001 >= period);
  wire [32:0] gap = going_up ? 33'(tgt_w - dem_w) : 33'(dem_w - tgt_w);
  wire [32:0] move = ({1'b0, step} >= gap) ? gap : {1'b0, step};
  wire signed [15:0] next_demand = !running ? 16'h0000 :
                                   !tick ? speed_demand :
                                   going_up ? 16'(dem_w + 18'(move)) :
                                   16'(dem_w - 18'(move));

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      speed_demand <= 16'h0000;
      tick_count <= 16'h0000;
    end
    else
    begin
      speed_demand <= next_demand;
      tick_count <= (!running || tick) ? 16'h0000 : tick_count + 16'h0001;
    end
  end

  // =====================================================
  // status word
  wire goal_met_flag = running && (speed_demand == clamped.speed);
  wire limit_hit_flag = clamped.limited;
  // mode specific bits only carry meaning in a selected mode; otherwise they read zero
  wire [1:0] mode_specific_bits = velocity_mode ? mode_pins : 2'b00;
  wire [15:0] next_status;
  assign next_status[`BIT_READY] = (pstate == PS_READY);
  assign next_status[`BIT_SWITCHED_ON] = (pstate == PS_SWITCHED_ON);
  assign next_status[`BIT_OP_ENABLED] = (pstate == PS_OP_ENABLED);
  assign next_status[`BIT_FAULT] = fault_in;
  assign next_status[`BIT_VOLTAGE] = voltage_present_flag;
  assign next_status[`BIT_EMERGENCY] = (pstate != PS_QUICK_STOP);
  assign next_status[`BIT_INHIBITED] = (pstate == PS_INHIBITED);
  assign next_status[`BIT_WARNING] = warning_in;
  assign next_status[`BIT_SYNC] = sync_in;
  assign next_status[`BIT_REMOTE] = 1'b1;
  assign next_status[`BIT_GOAL] = goal_met_flag;
  assign next_status[`BIT_LIMIT] = limit_hit_flag;
  assign next_status[`BIT_MODE_HI:`BIT_MODE_LO] = mode_specific_bits;
  assign next_status[14] = 1'b0;
  assign next_status[`BIT_LOOP] = (pstate == PS_OP_ENABLED) && loop_in;

  // =====================================================
  // interrupts
  wire [`EV_COUNT-1:0] events = {warning_in, fault_in, goal_met_flag, limit_hit_flag};
  wire [`EV_COUNT-1:0] clear_bits = hit(req, `ADDR_IRQ_CLEAR) ? req.wdata[`EV_COUNT-1:0] : 4'h0;
  // an event in the clearing cycle wins over the clear
  wire [`EV_COUNT-1:0] next_irq = (irq_status & ~clear_bits) | events;

  // =====================================================
  // read mux
  wire [31:0] rd_mux =
    (req.addr == `ADDR_STATE_FLAGS) ? {16'h0000, next_status} :
    (req.addr == `ADDR_SPEED_TARGET) ? {16'h0000, speed_target} :
    (req.addr == `ADDR_SPEED_DEMAND) ? {16'h0000, speed_demand} :
    (req.addr == `ADDR_SPEED_MEASURED) ? {16'h0000, speed_measured} :
    (req.addr == `ADDR_LOWER_LIMIT) ? speed_lower_limit :
    (req.addr == `ADDR_UPPER_LIMIT) ? speed_upper_limit :
    (req.addr == `ADDR_ACCEL_SPEED) ? accel_speed_step :
    (req.addr == `ADDR_ACCEL_TIME) ? {16'h0000, accel_time_step} :
    (req.addr == `ADDR_DECEL_SPEED) ? decel_speed_step :
    (req.addr == `ADDR_DECEL_TIME) ? {16'h0000, decel_time_step} :
    (req.addr == `ADDR_IRQ_STATUS) ? {28'h000_0000, irq_status} :
    (req.addr == `ADDR_IRQ_ENABLE) ? {28'h000_0000, irq_enable} :
    (req.addr == `ADDR_MODE) ? {24'h00_0000, op_mode} :
    32'h0000_0000;

  always_ff @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      irq_status <= 4'h0;
      IRQ_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      STATUS_O <= 16'h0000;
      SPEED_DEMAND_O <= 16'h0000;
    end
    else
    begin
      irq_status <= next_irq;
      IRQ_O <= |(next_irq & irq_enable);
      RDATA_O <= req.rd ? rd_mux : 32'h0000_0000;
      STATUS_O <= next_status;
      SPEED_DEMAND_O <= next_demand;
    end
  end

endmodule : drive_status_velocity

// ==== testbench/drive_status_sva.sv ====
`timescale 1ns/1ps
// ================================
// status word checks at the ports
module drive_status_sva
  import drive_status_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic [2:0] POWER_STATE_I,
  input wire logic SYNC_I,
  input wire logic LOOP_CLOSED_I,
  input wire logic [15:0] STATUS_O,
  input wire logic IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  // pins cross two sync stages and the output register, so three edges
  property p_ready; POWER_STATE_I == PS_READY |-> ##3 STATUS_O[0]; endproperty
  a_ready: assert property (p_ready) else $error("ready bit missing");
  property p_swon; POWER_STATE_I == PS_SWITCHED_ON |=> ##2 STATUS_O[1]; endproperty
  a_swon: assert property (p_swon) else $error("switched-on bit missing");
  property p_open; 1'b1 |-> ##3 STATUS_O[2] == $past(POWER_STATE_I == PS_OP_ENABLED, 3); endproperty
  a_open: assert property (p_open) else $error("enabled bit wrong");
  property p_qs; 1'b1 |-> ##3 STATUS_O[5] == ($past(POWER_STATE_I, 3) != PS_QUICK_STOP); endproperty
  a_qs: assert property (p_qs) else $error("quick stop bit wrong");
  property p_inhib; POWER_STATE_I == PS_INHIBITED ##1 POWER_STATE_I == PS_INHIBITED |-> ##2 STATUS_O[6]; endproperty
  a_inhib: assert property (p_inhib) else $error("inhibit bit missing");
  property p_sync; 1'b1 |-> ##3 STATUS_O[8] == $past(SYNC_I, 3); endproperty
  a_sync: assert property (p_sync) else $error("sync bit wrong");
  // the first edge after release still shows the reset word
  property p_remote; $past(RESETN_I) |-> STATUS_O[9]; endproperty
  a_remote: assert property (p_remote) else $error("remote bit low");
  property p_loop; 1'b1 |-> ##3 STATUS_O[15] == $past(POWER_STATE_I == PS_OP_ENABLED && LOOP_CLOSED_I, 3); endproperty
  a_loop: assert property (p_loop) else $error("loop bit wrong");
  c_loop: cover property (STATUS_O[15]);
  c_limit: cover property (STATUS_O[11]);
  c_irq: cover property ($rose(IRQ_O));
endmodule : drive_status_sva

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
// ================================
// fieldbus host: one-cycle strobes set just after the rising edge
module host_model
(
  input wire logic clk_i,
  output logic [15:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  logic [31:0] exp_q[$];
  initial
  begin
    addr_o = 16'h0000;
    wdata_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // stale data must not look valid once the strobe is gone
    wdata_o <= ~d;
  endtask : wr
  task rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd_o <= 1'b0;
  endtask : rd
endmodule : host_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
// ================================
// bench top
module tb;
  logic CLK_I, RESETN_I, WR_I, RD_I, IRQ_O, volt, flt, warn, sync, loop, rd_prev;
  logic [2:0] pst;
  logic [1:0] mb;
  logic signed [15:0] meas;
  logic signed [15:0] dem;
  logic [15:0] ADDR_I;
  logic [31:0] WDATA_I, RDATA_O, rv;
  int fail_count, checked, seed, i;
  localparam logic [31:0] zero = 32'h0000_0000;
  logic [15:0] ra [0:14] = '{16'h6041, 16'h6042, 16'h6043, 16'h6044, 16'h6046, 16'h6146, 16'h6048, 16'h6148,
    16'h6049, 16'h6149, 16'h7000, 16'h7001, 16'h7002, 16'h7003, 16'h1234};
  logic [31:0] re [0:14] = '{32'h0000_0220, 32'h0000_00C8, zero, zero, zero, 32'h0000_4E20, 32'h0000_01F4,
    32'h0000_0001, 32'h0000_01F4, 32'h0000_0001, zero, zero, zero, 32'h0000_0002, zero};

  drive_status_velocity uut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .POWER_STATE_I(pst), .VOLTAGE_PRESENT_I(volt), .FAULT_I(flt),
    .WARNING_I(warn), .SYNC_I(sync), .LOOP_CLOSED_I(loop), .MODE_BITS_I(mb), .SPEED_MEASURED_I(meas),
    .STATUS_O(), .SPEED_DEMAND_O(dem), .IRQ_O(IRQ_O));
  host_model host (.clk_i(CLK_I), .addr_o(ADDR_I), .wdata_o(WDATA_I), .wr_o(WR_I), .rd_o(RD_I));

  // expected word: goal assumes the ramp has settled
  function logic [31:0] sw(input logic [2:0] s, input logic v, input logic l);
    sw = {16'h0000, loop && s == 3'b100, 1'b0, v ? mb : 2'b00, l, v && s == 3'b100, 1'b1, sync, warn,
      s == 3'b001, s != 3'b101, volt, flt, s == 3'b100, s == 3'b011, s == 3'b010};
  endfunction : sw
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) rd_prev <= RD_I;
  always @(negedge CLK_I)
  begin
    if (rd_prev === 1'b1)
      chk(RDATA_O, host.exp_q.pop_front());
  end
  initial
  begin
    #100000;
    fail_count++;
    wrap_up;
  end

  initial
  begin
    seed = 21;
    fail_count = 0;
    checked = 0;
    rd_prev = 1'b0;
    RESETN_I = 1'b0;
    pst = 3'b000;
    {volt, flt, warn, sync, loop, mb} = 7'h00;
    meas = 16'h0000;
    repeat (3) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
    for (i = 0; i < 15; i++)
      host.rd(ra[i], re[i]);
    rv = $random(seed);
    host.wr(16'h6042, rv);
    host.wr(16'h6043, ~rv);
    host.rd(16'h6042, {16'h0000, rv[15:0]});
    host.rd(16'h6043, zero);
    host.wr(16'h6042, 32'h0000_03E8);
    for (i = 0; i < 8; i++)
    begin
      rv = $random(seed);
      @(posedge CLK_I);
      pst <= i[2:0];
      {volt, flt, warn, sync, loop, mb} <= rv[6:0];
      meas <= rv[31:16];
      repeat (12) @(posedge CLK_I);
      host.rd(16'h6041, sw(pst, 1'b1, 1'b0));
      host.rd(16'h6043, (i == 4) ? 32'h0000_03E8 : zero);
      host.rd(16'h6044, {16'h0000, meas});
    end
    host.wr(16'h6146, 32'h0000_0100);
    @(posedge CLK_I);
    pst <= 3'b100;
    repeat (12) @(posedge CLK_I);
    host.rd(16'h6043, 32'h0000_0100);
    @(negedge CLK_I);
    chk({16'h0000, dem}, 32'h0000_0100);
    host.rd(16'h6041, sw(pst, 1'b1, 1'b1));
    host.wr(16'h7003, zero);
    repeat (6) @(posedge CLK_I);
    host.rd(16'h6041, sw(pst, 1'b0, 1'b1));
    host.rd(16'h6043, zero);
    @(negedge CLK_I);
    chk({16'h0000, dem}, zero);
    host.wr(16'h7003, 32'h0000_0002);
    repeat (6) @(posedge CLK_I);
    // a slow accel step exposes a ramp that brakes with the wrong rate
    host.wr(16'h6048, 32'h0000_0001);
    host.wr(16'h6049, 32'h0000_03E8);
    host.wr(16'h6042, zero);
    repeat (6) @(posedge CLK_I);
    host.rd(16'h6043, zero);
    @(posedge CLK_I);
    pst <= 3'b000;
    {volt, flt, warn, sync, loop, mb} <= 7'h00;
    repeat (6) @(posedge CLK_I);
    host.wr(16'h7002, 32'h0000_000F);
    host.wr(16'h6046, 32'h0000_0064);
    host.wr(16'h6042, 32'h0000_0010);
    repeat (3) @(posedge CLK_I);
    host.rd(16'h6041, sw(pst, 1'b1, 1'b1));
    host.rd(16'h7000, 32'h0000_0001);
    @(negedge CLK_I);
    chk(32'(IRQ_O), zero);
    host.wr(16'h7001, 32'h0000_0001);
    repeat (2) @(negedge CLK_I);
    chk(32'(IRQ_O), 32'h0000_0001);
    host.wr(16'h6042, 32'h0000_0080);
    host.wr(16'h7002, 32'h0000_0001);
    repeat (2) @(negedge CLK_I);
    chk(32'(IRQ_O), zero);
    host.rd(16'h6041, sw(pst, 1'b1, 1'b0));
    repeat (4) @(posedge CLK_I);
    wrap_up;
  end
endmodule : tb

bind drive_status_velocity drive_status_sva sva (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .POWER_STATE_I(POWER_STATE_I),
  .SYNC_I(SYNC_I), .LOOP_CLOSED_I(LOOP_CLOSED_I), .STATUS_O(STATUS_O), .IRQ_O(IRQ_O));
